// ---- hw/bwdt_counter.sv ----
`timescale 1ns/1ps
module bwdt_counter #(
  parameter int unsigned W = 26
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control from command logic
  bwdt_cnt_if.cnt  c
);
  import bwdt_pkg::*;

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  // load wins over decrement so a keep-alive on the last cycle still saves us
  assign count_nxt = c.load ? c.load_val - W'(1) :
                     (c.run && count_r != '0) ? count_r - W'(1) : count_r;
  assign c.expired = c.run && !c.load && (count_r == '0);

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reload;
    @(posedge clk) disable iff (!rst_n)
    (ce && c.load) |=> (count_r == $past(c.load_val) - W'(1));
  endproperty
  a_reload: assert property (p_reload) else $error("countdown not restarted from full interval");

  property p_idle_hold;
    @(posedge clk) disable iff (!rst_n)
    (!c.run && !c.load) |=> $stable(count_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("countdown moved while not running");

endmodule

// ---- hw/bwdt_top.sv ----
`timescale 1ns/1ps
module bwdt_top #(
  parameter logic [bwdt_pkg::CNT_W-1:0] P250_CYC  = bwdt_pkg::T250_CYC,
  parameter logic [bwdt_pkg::CNT_W-1:0] P500_CYC  = bwdt_pkg::T500_CYC,
  parameter logic [bwdt_pkg::CNT_W-1:0] P1S_CYC   = bwdt_pkg::T1S_CYC,
  parameter logic [bwdt_pkg::CNT_W-1:0] PULSE_CYC = bwdt_pkg::RST_PULSE_CYC
) (
  // clock, reset, enable
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // local processor write port
  input  wire logic [31:0] LOC_ADDR,
  input  wire logic        LOC_WR,
  input  wire logic [7:0]  LOC_WDATA,
  // board resets
  output logic             CPU_RST_N,
  output logic             PRI_PCI_RST_N,
  output logic             SEC_PCI_RST_N,
  // status
  output logic             WD_ACTIVE
);
  import bwdt_pkg::*;

  // ----------------------------------------------------------------
  // state and wires
  // ----------------------------------------------------------------
  logic             en_r;
  logic             en_nxt;
  logic [1:0]       sel_r;
  logic [1:0]       sel_nxt;
  logic             pulse_r;
  logic             pulse_nxt;
  logic [CNT_W-1:0] pulse_cnt_r;
  logic [CNT_W-1:0] pulse_cnt_nxt;
  logic             hit;
  logic             cmd_en;
  logic             cmd_kick;
  logic [1:0]       cmd_sel;
  logic             disable_cmd;
  logic             expire;
  logic             pulse_done;

  bwdt_cnt_if #(.W(CNT_W)) cif ();

  // ----------------------------------------------------------------
  // interval decode
  // ----------------------------------------------------------------
  // unused code 3 falls back to the longest interval, the safest choice
  function automatic logic [CNT_W-1:0] period_cyc(input logic [1:0] s);
    logic [CNT_W-1:0] v;
    v = P1S_CYC;
    case (s)
      SEL_250MS: v = P250_CYC;
      SEL_500MS: v = P500_CYC;
      SEL_1S:    v = P1S_CYC;
      default:   v = P1S_CYC;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // address decode and command fields
  // ----------------------------------------------------------------
  // full 32-bit compare; partial decode would alias onto other devices
  assign hit         = LOC_WR && (LOC_ADDR == WD_ADDR);
  assign cmd_en      = LOC_WDATA[EN_BIT];
  assign cmd_kick    = LOC_WDATA[KICK_BIT];
  assign cmd_sel     = LOC_WDATA[SEL_MSB:SEL_LSB];
  assign disable_cmd = hit && !cmd_en;

  // ----------------------------------------------------------------
  // countdown control
  // ----------------------------------------------------------------
  // load on first enable or on keep-alive, always from the fresh selection
  assign cif.load     = hit && cmd_en && (!en_r || cmd_kick);
  assign cif.load_val = period_cyc(sel_nxt);
  assign cif.run      = en_r && !pulse_r;

  // ----------------------------------------------------------------
  // expiry and reset pulse
  // ----------------------------------------------------------------
  assign expire     = cif.expired && en_r && !pulse_r;
  assign pulse_done = pulse_r && (pulse_cnt_r == '0);

  // a disable write wins over everything, even a pulse in progress
  assign en_nxt        = hit ? cmd_en : (pulse_done ? 1'h0 : en_r);
  assign sel_nxt       = hit ? cmd_sel : sel_r;
  assign pulse_nxt     = disable_cmd ? 1'h0 :
                         expire      ? 1'h1 :
                         pulse_done  ? 1'h0 : pulse_r;
  assign pulse_cnt_nxt = expire ? PULSE_CYC - CNT_W'(1) :
                         (pulse_r && pulse_cnt_r != '0) ? pulse_cnt_r - CNT_W'(1) : pulse_cnt_r;

  // control registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      en_r        <= EN_RST;
      sel_r       <= SEL_RST;
      pulse_r     <= 1'h0;
      pulse_cnt_r <= '0;
    end else if (CE) begin
      en_r        <= en_nxt;
      sel_r       <= sel_nxt;
      pulse_r     <= pulse_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // one pulse drives all three resets so they can never skew apart
  assign CPU_RST_N     = !pulse_r;
  assign PRI_PCI_RST_N = !pulse_r;
  assign SEC_PCI_RST_N = !pulse_r;
  assign WD_ACTIVE     = en_r;

  // ----------------------------------------------------------------
  // countdown instance
  // ----------------------------------------------------------------
  bwdt_counter #(
    .W     (CNT_W)
  ) u_counter (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .c     (cif.cnt)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_rst_all;
    !CPU_RST_N && !PRI_PCI_RST_N && !SEC_PCI_RST_N;
  endsequence

  sequence s_rst_none;
    CPU_RST_N && PRI_PCI_RST_N && SEC_PCI_RST_N;
  endsequence

  property p_off_quiet;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !en_r |-> s_rst_none;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("reset asserted while watchdog disabled");

  property p_off_frozen;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !en_r |-> !cif.run && !cif.expired;
  endproperty
  a_off_frozen: assert property (p_off_frozen) else $error("countdown running while disabled");

  property p_disable;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && disable_cmd) |=> s_rst_none [*3];
  endproperty
  a_disable: assert property (p_disable) else $error("reset after disable command");

  property p_expire;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && expire && !disable_cmd) |=> s_rst_all ##0 WD_ACTIVE;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not reset cpu and both pci buses");

  property p_decode;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && LOC_WR && LOC_ADDR != WD_ADDR && !pulse_done) |=> $stable(en_r) && $stable(sel_r);
  endproperty
  a_decode: assert property (p_decode) else $error("write to foreign address changed watchdog");

  property p_period;
    @(posedge CORE_CLK) disable iff (!RST_N)
    cif.load |-> (cif.load_val == P250_CYC || cif.load_val == P500_CYC || cif.load_val == P1S_CYC);
  endproperty
  a_period: assert property (p_period) else $error("interval is not one of the three allowed");

  property p_enable_loads;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (hit && cmd_en && !en_r) |-> cif.load && cif.load_val == period_cyc(cmd_sel);
  endproperty
  a_enable_loads: assert property (p_enable_loads) else $error("enable did not restart full interval");

  // reset pulse: all three outputs in step, loaded, counted down, released
  property p_all_equal;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CPU_RST_N == PRI_PCI_RST_N) && (CPU_RST_N == SEC_PCI_RST_N);
  endproperty
  a_all_equal: assert property (p_all_equal) else $error("board reset outputs differ");

  property p_pulse_load;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && expire) |=> (pulse_cnt_r == PULSE_CYC - CNT_W'(1));
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("reset pulse width not loaded on expiry");

  // a pulse in progress only ends by running out or by a disable write
  property p_pulse_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && pulse_r && !pulse_done && !disable_cmd) |=>
      s_rst_all ##0 (pulse_cnt_r == $past(pulse_cnt_r) - CNT_W'(1));
  endproperty
  a_pulse_step: assert property (p_pulse_step) else $error("reset pulse cut short or not counting");

  property p_pulse_end;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && pulse_done && !hit) |=> s_rst_none ##0 !WD_ACTIVE;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("reset pulse did not end cleanly");

  // keep-alive: every enabled write with the keep-alive bit reloads
  property p_kick_restart;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (hit && cmd_en && cmd_kick) |-> cif.load;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("keep-alive did not reload countdown");

  // a reload even on the very last cycle must hold the resets off
  property p_kick_saves;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && cif.load && !pulse_r) |=> s_rst_none;
  endproperty
  a_kick_saves: assert property (p_kick_saves) else $error("reset fired despite keep-alive");

  property p_disable_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && disable_cmd) |=> !WD_ACTIVE && !cif.run;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("watchdog still active after disable");

endmodule

// ---- shared/bwdt_cnt_if.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// control between the command logic and the countdown
// ------------------------------------------------------------------
interface bwdt_cnt_if #(
  parameter int unsigned W = 26
);
  logic         load;
  logic         run;
  logic [W-1:0] load_val;
  logic         expired;

  modport ctl (output load, output run, output load_val, input expired);
  modport cnt (input load, input run, input load_val, output expired);
endinterface

// ---- shared/bwdt_pkg.sv ----
package bwdt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 50000;
  localparam int unsigned CNT_W        = 26;
  localparam int unsigned T250_MS      = 250;
  localparam int unsigned T500_MS      = 500;
  localparam int unsigned T1S_MS       = 1000;
  localparam int unsigned RST_PULSE_US = 20;

  // least times: cycles rounded up
  localparam logic [CNT_W-1:0] T250_CYC      = CNT_W'(T250_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] T500_CYC      = CNT_W'(T500_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] T1S_CYC       = CNT_W'(T1S_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] RST_PULSE_CYC = CNT_W'((RST_PULSE_US * CLK_KHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // control register: address and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] WD_ADDR  = 32'hFF10_0000;
  localparam int unsigned EN_BIT   = 0;
  localparam int unsigned SEL_LSB  = 1;
  localparam int unsigned SEL_MSB  = 2;
  localparam int unsigned KICK_BIT = 3;
  localparam logic        EN_RST   = 1'h0;
  localparam logic [1:0]  SEL_RST  = 2'h0;

  // interval selection codes
  localparam logic [1:0] SEL_250MS = 2'h0;
  localparam logic [1:0] SEL_500MS = 2'h1;
  localparam logic [1:0] SEL_1S    = 2'h2;

endpackage

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // small periods keep the run short
  // ----------------------------------------------------------------
  localparam int P250 = 8;
  localparam int P500 = 12;
  localparam int P1S  = 16;
  localparam int PW   = 3;

  // clock, reset, enable
  logic        CORE_CLK = 1'b0;
  logic        RST_N    = 1'b0;
  logic        CE       = 1'b1;
  // write port
  logic [31:0] LOC_ADDR  = 32'h0000_0000;
  logic        LOC_WR    = 1'b0;
  logic [7:0]  LOC_WDATA = 8'h00;
  // outputs
  logic        CPU_RST_N;
  logic        PRI_PCI_RST_N;
  logic        SEC_PCI_RST_N;
  logic        WD_ACTIVE;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  bwdt_top #(.P250_CYC(26'(P250)), .P500_CYC(26'(P500)), .P1S_CYC(26'(P1S)), .PULSE_CYC(26'(PW))) bwdt_top_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .LOC_ADDR(LOC_ADDR), .LOC_WR(LOC_WR),
    .LOC_WDATA(LOC_WDATA), .CPU_RST_N(CPU_RST_N), .PRI_PCI_RST_N(PRI_PCI_RST_N),
    .SEC_PCI_RST_N(SEC_PCI_RST_N), .WD_ACTIVE(WD_ACTIVE));

  // 50 MHz clock
  always #10 CORE_CLK = ~CORE_CLK;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write, released at the taking edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    LOC_ADDR  <= a;
    LOC_WDATA <= d;
    LOC_WR    <= 1'b1;
    @(posedge CORE_CLK);
    LOC_WR    <= 1'b0;
  endtask

  // edges to expiry, then pulse width; both PCI resets are low once CPU_RST_N asserts
  task automatic meas(input int n);
    int c;
    c = 0;
    #1;
    while (CPU_RST_N === 1'b1 && c < 100) begin
      @(posedge CORE_CLK);
      #1;
      c++;
    end
    chk(c, n);
    chk({PRI_PCI_RST_N, SEC_PCI_RST_N}, 2'h0);
    c = 0;
    while (CPU_RST_N === 1'b0 && c < 100) begin
      @(posedge CORE_CLK);
      #1;
      c++;
    end
    chk(c, PW);
    chk(WD_ACTIVE, 1'h0);
  endtask

  // no reset may appear for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge CORE_CLK);
      #1;
      chk({CPU_RST_N, PRI_PCI_RST_N, SEC_PCI_RST_N}, 3'h7);
    end
  endtask

  // ordinary cases: write data beside its expected period
  logic [7:0] row_d [4] = '{8'h01, 8'h03, 8'h05, 8'h07};
  int         row_n [4] = '{P250, P500, P1S, P1S};

  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'h1;
    #1;
    chk({CPU_RST_N, PRI_PCI_RST_N, SEC_PCI_RST_N, WD_ACTIVE}, 4'hE);
    for (int i = 0; i < 4; i++) begin
      wr(32'hFF10_0000, row_d[i]);
      meas(row_n[i]);
    end
    // keep-alive while disabled must not start anything
    wr(32'hFF10_0000, 8'h08);
    #1;
    chk(WD_ACTIVE, 1'b0);
    quiet(2 * P1S);
    // enable at a neighbouring address is ignored
    wr(32'hFF10_0004, 8'h01);
    #1;
    chk(WD_ACTIVE, 1'b0);
    quiet(2 * P250);
    // disable in mid-count stops the countdown for good
    wr(32'hFF10_0000, 8'h01);
    #1;
    chk(WD_ACTIVE, 1'b1);
    repeat (4) @(posedge CORE_CLK);
    wr(32'hFF10_0000, 8'h00);
    #1;
    chk(WD_ACTIVE, 1'b0);
    quiet(3 * P250);
    // keep-alive in the very last cycle still restarts the full period
    wr(32'hFF10_0000, 8'h01);
    repeat (6) @(posedge CORE_CLK);
    wr(32'hFF10_0000, 8'h0B);
    meas(P500);
    // clock enable low freezes the countdown
    wr(32'hFF10_0000, 8'h01);
    CE <= 1'h0;
    quiet(9);
    @(posedge CORE_CLK);
    CE <= 1'h1;
    meas(P250);
    // select change without keep-alive does not restart the countdown
    wr(32'hFF10_0000, 8'h01);
    wr(32'hFF10_0000, 8'h03);
    meas(P250 - 2);
    // reset in mid-count cancels the watchdog
    wr(32'hFF10_0000, 8'h01);
    RST_N <= 1'h0;
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    #1;
    chk(WD_ACTIVE, 1'b0);
    quiet(2 * P250);
    tally_and_finish;
  end
endmodule
